// ===== testbench/stpcs_timer_model.sv
// Purpose: far side of the block: three timer counters and their count pins
// Assumes: pins move 30 ns after a rising edge, well clear of sampling
// Notes: counters step once per tick pulse, as a timer's counter unit would
module stpcs_timer_model
    import stpcs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control
    input wire logic run_i,
    input wire logic clr_i,
    // ticks from the block
    input wire logic [2:0] tick_i,
    // pins and counters
    output logic [2:0] pin_o,
    output logic [2:0][7:0] cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] ph_r;

    initial pin_o = 3'h0;

    // phase count gives a half period of two clocks, below clock/2.5
    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            ph_r <= 2'h0;
        end else begin
            ph_r <= ph_r + 2'h1;
        end
    end

    // pins only move while running, so sources switch on a quiet pin
    always @(posedge clk_i) begin
        if (run_i && ph_r[0]) begin
            pin_o <= #30 ~pin_o;
        end
    end

    // one counter step per tick pulse
    always @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            if (rst_i || clr_i) begin
                cnt_o[k] <= 8'h00;
            end else if (tick_i[k]) begin
                cnt_o[k] <= cnt_o[k] + 8'h01;
            end
        end
    end
endmodule : stpcs_timer_model

// ===== testbench/tb.sv
// Purpose: self-checking bench for the shared prescaler and clock select
// Assumes: 10 MHz clock, far-side timers and pins from stpcs_timer_model
// Notes: register cases run from a table; timing cases are written out
module tb
    import stpcs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i, rst_i, reg_wr_i, reg_rd_i, run_r, clr_r, shr_rst, t0_rst;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [2:0] pin, tick;
    logic [1:0] misc;
    logic [2:0][7:0] cnt;
    int fails = 0;
    int n_compared = 0;
    int n;
    int divs [4] = '{8, 64, 256, 1024};
    // register cases: address, write data, value read back
    logic [7:0] rows [9][3] = '{
        '{8'h20, 8'hFF, 8'h8F}, '{8'h20, 8'h0C, 8'h0C}, '{8'h21, 8'hFF, 8'h07},
        '{8'h22, 8'h05, 8'h05}, '{8'h23, 8'h06, 8'h06}, '{8'h30, 8'h5A, 8'h00},
        '{8'h20, 8'h00, 8'h00}, '{8'h21, 8'h00, 8'h00}, '{8'h22, 8'h00, 8'h00}};

    stpcs_top #(.NUM_TIMERS(3)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .ext_count_input_i(pin), .timer_tick_o(tick), .shared_prescaler_reset_o(shr_rst),
        .timer0_prescaler_reset_o(t0_rst), .misc_ctrl_o(misc));

    stpcs_timer_model far_u (
        .clk_i(clk_i), .rst_i(rst_i), .run_i(run_r), .clr_i(clr_r), .tick_i(tick),
        .pin_o(pin), .cnt_o(cnt));

    // clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // write: one strobe cycle, the slave never stalls
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // read: data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : rd

    // cycles until timer k ticks; a lost tick must not hang the run
    task automatic wait_tick(input int k, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk_i);
            #1;
            cyc++;
        end while (tick[k] !== 1'b1 && cyc < 1100);
        if (cyc >= 1100) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_tick

    initial begin
        rst_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        run_r = 1'b0;
        clr_r = 1'b0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        #1;
        chk({8'h00, cnt[0] | cnt[1] | cnt[2]}, 16'h0000);
        chk({9'h000, tick, shr_rst, t0_rst, misc}, 16'h0000);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], rows[i][2]);
        end
        // control bits pass out; reset bits are not kept without hold
        wr(8'h20, 8'h0F);
        #1;
        chk({12'h000, shr_rst, t0_rst, misc}, 16'h0003);
        wr(8'h20, 8'h00);
        // each tap after a prescaler reset, timer1 parked on divide-by-8
        wr(8'h22, 8'h02);
        for (int s = 2; s <= 5; s++) begin
            wr(8'h21, 8'(s));
            wr(8'h20, 8'h01);
            wait_tick(0, n);
            chk(16'(n), 16'(divs[s - 2]));
            chk({15'h0000, tick[1]}, 16'h0001);
            wait_tick(0, n);
            chk(16'(n), 16'(divs[s - 2]));
        end
        wr(8'h23, 8'h01);
        repeat (4) begin
            @(posedge clk_i);
            #1;
            chk({15'h0000, tick[2]}, 16'h0001);
        end
        // hold both resets, then count the pins: they bypass the prescaler
        wr(8'h20, 8'h83);
        wr(8'h22, 8'h06);
        wr(8'h23, 8'h07);
        rd(8'h20, 8'h83);
        @(posedge clk_i);
        clr_r <= 1'b1;
        @(posedge clk_i);
        clr_r <= 1'b0;
        run_r <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk({13'h0000, tick}, 16'h0000);
        @(posedge clk_i);
        #1;
        chk({13'h0000, tick}, 16'h0004);
        @(posedge clk_i);
        #1;
        chk({13'h0000, tick}, 16'h0000);
        repeat (35) @(posedge clk_i);
        run_r <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        chk({cnt[1], cnt[2]}, 16'h0A0A);
        chk({8'h00, cnt[0]}, 16'h0000);
        chk({14'h0000, shr_rst, t0_rst}, 16'h0003);
        // release the hold: both timers restart on the same cycle
        wr(8'h22, 8'h02);
        wr(8'h20, 8'h00);
        #1;
        chk({14'h0000, shr_rst, t0_rst}, 16'h0000);
        wait_tick(0, n);
        chk(16'(n), 16'd1024);
        chk({15'h0000, tick[1]}, 16'h0001);
        rd(8'h20, 8'h00);
        wr(8'h20, 8'h01);
        #1;
        chk({15'h0000, shr_rst}, 16'h0000);
        rd(8'h20, 8'h00);
        // count read 41 cycles after the restart shows bits 9:2 of 41
        repeat (38) @(posedge clk_i);
        rd(8'h24, 8'h0A);
        report_and_stop();
    end
endmodule : tb

// ===== verilog/stpcs_ext_sync.sv
// Purpose: synchroniser and edge detector for one external count pin
// Assumes: pin is asynchronous to clk_i; each half period exceeds one clock
// Notes: rise_o/fall_o are combinational from flops; the top registers them
module stpcs_ext_sync
    import stpcs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin
    input wire logic pin_i,
    // detected edges
    output logic rise_o,
    output logic fall_o
);

    logic latch_r;
    logic sync_r;
    logic prev_r;

    // stands in for the latch transparent in the high phase: it closes at the falling edge
    always_ff @(negedge clk_i) begin
        if (rst_i) begin
            latch_r <= 1'b0;
        end else begin
            latch_r <= pin_i;
        end
    end

    // rising-edge sampling, one sample per clock, then one delay stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync_r <= latch_r;
            prev_r <= sync_r;
        end
    end

    // edge detection on the sampled level only
    assign rise_o = sync_r & ~prev_r;
    assign fall_o = ~sync_r & prev_r;

    property p_rise_once;
        @(posedge clk_i) disable iff (rst_i)
        rise_o |=> !rise_o;
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("rise pulse longer than one cycle");

endmodule : stpcs_ext_sync

// ===== verilog/stpcs_pkg.sv
// Purpose: shared constants and types of the timer prescaler and clock select
// Assumes: 8-bit register port, 10 MHz system clock, three timers
// Notes: register offsets are byte addresses on the plain register port
package stpcs_pkg;

    // clock period of the system clock in ns
    localparam int CLK_PERIOD_NS = 100;

    // register map
    localparam logic [7:0] SFIO_OFFSET = 8'h20;
    localparam logic [7:0] TSEL_BASE = 8'h21;
    localparam logic [7:0] PSTAT_OFFSET = 8'h24;
    localparam logic [7:0] SFIO_RESET = 8'h00;
    localparam logic [2:0] TSEL_RESET = 3'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // field positions of the special function register
    localparam int SFIO_HOLD_BIT = 7;
    localparam int SFIO_CMPMUX_BIT = 3;
    localparam int SFIO_PULLUP_BIT = 2;
    localparam int SFIO_T0RST_BIT = 1;
    localparam int SFIO_SHRST_BIT = 0;

    // prescaler width and tap widths (tap fires when its low bits are all ones)
    localparam int PRESCALE_W = 10;
    localparam int TAP8_W = 3;
    localparam int TAP64_W = 6;
    localparam int TAP256_W = 8;
    localparam int TAP1024_W = 10;
    localparam logic [9:0] PRESCALE_RESET = 10'h000;

    // clock source encodings
    typedef enum logic [2:0] {
        CSS_STOP = 3'h0,
        CSS_SYS = 3'h1,
        CSS_DIV8 = 3'h2,
        CSS_DIV64 = 3'h3,
        CSS_DIV256 = 3'h4,
        CSS_DIV1024 = 3'h5,
        CSS_EXT_FALL = 3'h6,
        CSS_EXT_RISE = 3'h7
    } stpcs_css_type;

    // special function register layout
    typedef struct packed {
        logic hold;
        logic [2:0] rsv;
        logic cmp_mux;
        logic pullup_off;
        logic t0_rst;
        logic shared_rst;
    } stpcs_sfio_type;

    // prescaler taps as one bundle
    typedef struct packed {
        logic div1024;
        logic div256;
        logic div64;
        logic div8;
    } stpcs_taps_type;

endpackage : stpcs_pkg

// ===== verilog/stpcs_top.sv
// Purpose: shared prescaler and per-timer clock source select for three timers
// Assumes: plain register port, one 10 MHz clock, synchronous active-high reset
// Notes: ticks come from flops as one-cycle pulses, except source 1 which holds high; the timers sample them on the next edge
//
// Contract
// - Source 1 ticks the timer on every system clock.
// - Four prescaled ticks are offered: clock divided by 8, 64, 256, 1024.
// - Source 0 gives no tick; the timer stays stopped.
// - One free-running prescaler serves all timers; each keeps its own source.
// - First prescaled tick comes 1 to N+1 clocks after enabling.
// - A prescaler reset restarts the period for every attached timer.
// - The external pin is sampled once per clock, then edge detected.
// - Sample registers use the rising edge; latch transparent while clock high.
// - One tick per rising edge for source 7, per falling edge for 6.
// - Pin edge to counter update takes 2.5 to 3.5 clocks.
// - External ticks go straight to the timer, never through the prescaler.
// - While hold is set, written reset bits are kept, timers stay halted; here a held shared reset halts only timers on sources 2 to 5.
// - Clearing hold clears both reset bits so timers restart together.
// - Shared reset bit resets the prescaler and clears at once unless held.
//
// Decided for this implementation: the strobed register port.
module stpcs_top
    import stpcs_pkg::*;
#(
    parameter int NUM_TIMERS = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // external count pins
    input wire logic [NUM_TIMERS-1:0] ext_count_input_i,
    // timer ticks
    output logic [NUM_TIMERS-1:0] timer_tick_o,
    // prescaler resets and pass-through control bits
    output logic shared_prescaler_reset_o,
    output logic timer0_prescaler_reset_o,
    output logic [1:0] misc_ctrl_o
);

    stpcs_sfio_type sfio_r;
    stpcs_sfio_type sfio_nxt;
    logic [PRESCALE_W-1:0] cnt_r;
    logic [PRESCALE_W-1:0] cnt_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [2:0] sel_r [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] tick_r;
    logic [NUM_TIMERS-1:0] tick_nxt;
    logic [NUM_TIMERS-1:0] ext_rise;
    logic [NUM_TIMERS-1:0] ext_fall;
    stpcs_taps_type taps;

    // address decode
    wire sfio_hit = (reg_addr_i == SFIO_OFFSET);
    wire pstat_hit = (reg_addr_i == PSTAT_OFFSET);
    wire sfio_wr = reg_wr_i & sfio_hit;
    wire wr_hold = reg_wdata_i[SFIO_HOLD_BIT];
    wire wr_shrst = reg_wdata_i[SFIO_SHRST_BIT];
    wire wr_t0rst = reg_wdata_i[SFIO_T0RST_BIT];

    // the written reset acts in its own write cycle even when it is not kept
    wire shared_rst_act = sfio_r.shared_rst | (sfio_wr & wr_shrst);
    wire t0_rst_act = sfio_r.t0_rst | (sfio_wr & wr_t0rst);

    // reset bits are kept only with hold; without it they clear at once,
    // and a write that drops hold clears both in the same cycle
    always_comb begin
        sfio_nxt = sfio_r;
        if (sfio_wr) begin
            sfio_nxt.hold = wr_hold;
            sfio_nxt.rsv = 3'h0;
            sfio_nxt.cmp_mux = reg_wdata_i[SFIO_CMPMUX_BIT];
            sfio_nxt.pullup_off = reg_wdata_i[SFIO_PULLUP_BIT];
            sfio_nxt.shared_rst = wr_hold & wr_shrst;
            sfio_nxt.t0_rst = wr_hold & wr_t0rst;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sfio_r <= stpcs_sfio_type'(SFIO_RESET);
        end else begin
            sfio_r <= sfio_nxt;
        end
    end

    // free-running prescaler; only its own reset stops it, never a source choice
    assign cnt_nxt = shared_rst_act ? PRESCALE_RESET : cnt_r + 10'h001;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= PRESCALE_RESET;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // taps fire when the low bits are all ones; held off during reset so
    // a halted group of timers cannot advance while being configured
    assign taps.div8 = (&cnt_r[TAP8_W-1:0]) & ~shared_rst_act;
    assign taps.div64 = (&cnt_r[TAP64_W-1:0]) & ~shared_rst_act;
    assign taps.div256 = (&cnt_r[TAP256_W-1:0]) & ~shared_rst_act;
    assign taps.div1024 = (&cnt_r[TAP1024_W-1:0]) & ~shared_rst_act;

    // source select: external edges bypass the prescaler entirely
    function automatic logic pick_tick(input logic [2:0] sel, input stpcs_taps_type tp,
                                       input logic rise, input logic fall);
        logic t;
        t = 1'b0;
        unique case (stpcs_css_type'(sel))
            CSS_STOP: t = 1'b0;
            CSS_SYS: t = 1'b1;
            CSS_DIV8: t = tp.div8;
            CSS_DIV64: t = tp.div64;
            CSS_DIV256: t = tp.div256;
            CSS_DIV1024: t = tp.div1024;
            CSS_EXT_FALL: t = fall;
            CSS_EXT_RISE: t = rise;
        endcase
        return t;
    endfunction : pick_tick

    // per-timer selection register, synchroniser and tick flop
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
        localparam logic [7:0] SEL_OFFSET = TSEL_BASE + 8'(g);
        wire sel_wr = reg_wr_i & (reg_addr_i == SEL_OFFSET);

        stpcs_ext_sync u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(ext_count_input_i[g]),
            .rise_o(ext_rise[g]),
            .fall_o(ext_fall[g])
        );

        // each timer keeps its own source choice
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sel_r[g] <= TSEL_RESET;
            end else if (sel_wr) begin
                sel_r[g] <= reg_wdata_i[2:0];
            end
        end

        assign tick_nxt[g] = pick_tick(sel_r[g], taps, ext_rise[g], ext_fall[g]);

        // the tick flop is the last stage of the external path latency in this block
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                tick_r[g] <= 1'b0;
            end else begin
                tick_r[g] <= tick_nxt[g];
            end
        end

        property p_sys_tick;
            @(posedge clk_i) disable iff (rst_i)
            (sel_r[g] == CSS_SYS) && !sel_wr |=> tick_r[g];
        endproperty
        a_sys_tick: assert property (p_sys_tick) else $error("system clock source missed a tick");

        property p_stop;
            @(posedge clk_i) disable iff (rst_i)
            (sel_r[g] == CSS_STOP) && !sel_wr |=> !tick_r[g];
        endproperty
        a_stop: assert property (p_stop) else $error("stopped timer received a tick");

        property p_div8;
            @(posedge clk_i) disable iff (rst_i)
            tick_r[g] && ($past(sel_r[g]) == CSS_DIV8) |-> $past(cnt_r[TAP8_W-1:0]) == 3'h7;
        endproperty
        a_div8: assert property (p_div8) else $error("divide by 8 tick off its tap");

        property p_div64;
            @(posedge clk_i) disable iff (rst_i)
            tick_r[g] && ($past(sel_r[g]) == CSS_DIV64) |-> $past(cnt_r[TAP64_W-1:0]) == 6'h3F;
        endproperty
        a_div64: assert property (p_div64) else $error("divide by 64 tick off its tap");

        property p_div256;
            @(posedge clk_i) disable iff (rst_i)
            tick_r[g] && ($past(sel_r[g]) == CSS_DIV256) |-> $past(cnt_r[TAP256_W-1:0]) == 8'hFF;
        endproperty
        a_div256: assert property (p_div256) else $error("divide by 256 tick off its tap");

        property p_div1024;
            @(posedge clk_i) disable iff (rst_i)
            tick_r[g] && ($past(sel_r[g]) == CSS_DIV1024) |-> $past(cnt_r) == 10'h3FF;
        endproperty
        a_div1024: assert property (p_div1024) else $error("divide by 1024 tick off its tap");

        property p_ext_rise;
            @(posedge clk_i) disable iff (rst_i)
            (sel_r[g] == CSS_EXT_RISE) && ext_rise[g] && !sel_wr |=> tick_r[g];
        endproperty
        a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge gave no tick");

        property p_ext_fall;
            @(posedge clk_i) disable iff (rst_i)
            (sel_r[g] == CSS_EXT_FALL) && ext_fall[g] && !sel_wr |=> tick_r[g];
        endproperty
        a_ext_fall: assert property (p_ext_fall) else $error("falling pin edge gave no tick");

        property p_ext_direct;
            @(posedge clk_i) disable iff (rst_i)
            tick_r[g] && ($past(sel_r[g]) == CSS_EXT_FALL) |-> $past(ext_fall[g]);
        endproperty
        a_ext_direct: assert property (p_ext_direct) else $error("external tick without pin edge");

        property p_pin_latency;
            @(posedge clk_i) disable iff (rst_i)
            (sel_r[g] == CSS_EXT_RISE) && !sel_wr && $rose(ext_rise[g]) |=> tick_r[g] ##1 !tick_r[g];
        endproperty
        a_pin_latency: assert property (p_pin_latency) else $error("external tick late or stretched");
    end

    // read mux; reserved bits read as zero, unmapped addresses read zero
    wire [7:0] sfio_rd = {sfio_r.hold, 3'h0, sfio_r.cmp_mux, sfio_r.pullup_off,
                          sfio_r.t0_rst, sfio_r.shared_rst};
    wire [7:0] pstat_rd = cnt_r[PRESCALE_W-1:2];

    always_comb begin
        rdata_nxt = RDATA_RESET;
        if (reg_rd_i) begin
            if (sfio_hit) begin
                rdata_nxt = sfio_rd;
            end else if (pstat_hit) begin
                rdata_nxt = pstat_rd;
            end
            for (int k = 0; k < NUM_TIMERS; k++) begin
                if (reg_addr_i == TSEL_BASE + 8'(k)) begin
                    rdata_nxt = {5'h00, sel_r[k]};
                end
            end
        end
    end

    // read data stand for the one cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= RDATA_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign timer_tick_o = tick_r;
    assign shared_prescaler_reset_o = shared_rst_act;
    assign timer0_prescaler_reset_o = t0_rst_act;
    assign misc_ctrl_o = {sfio_r.cmp_mux, sfio_r.pullup_off};

    // prescaler keeps counting whenever it is not reset; the sampled reset
    // keeps the release edge out, where disable iff already sees the new level
    property p_free_run;
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && !shared_rst_act |=> cnt_r == $past(cnt_r) + 10'h001;
    endproperty
    a_free_run: assert property (p_free_run) else $error("prescaler stalled outside reset");

    property p_restart;
        @(posedge clk_i) disable iff (rst_i)
        shared_rst_act |=> cnt_r == PRESCALE_RESET;
    endproperty
    a_restart: assert property (p_restart) else $error("prescaler reset did not restart period");

    property p_held;
        @(posedge clk_i) disable iff (rst_i)
        sfio_r.hold && sfio_r.shared_rst && !sfio_wr |=> sfio_r.shared_rst && taps == 4'h0;
    endproperty
    a_held: assert property (p_held) else $error("held prescaler reset was lost");

    property p_t0_held;
        @(posedge clk_i) disable iff (rst_i)
        sfio_r.hold && sfio_r.t0_rst && !sfio_wr |=> sfio_r.t0_rst && timer0_prescaler_reset_o;
    endproperty
    a_t0_held: assert property (p_t0_held) else $error("held timer0 reset was lost");

    // releasing the hold restarts the shared period, so all held timers start together
    property p_hold_release;
        @(posedge clk_i) disable iff (rst_i)
        sfio_r.hold && sfio_r.shared_rst && sfio_wr && !wr_hold |=> cnt_r == PRESCALE_RESET;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold release did not restart period");

    property p_release;
        @(posedge clk_i) disable iff (rst_i)
        sfio_wr && !wr_hold |=> !sfio_r.shared_rst && !sfio_r.t0_rst &&
            (!shared_prescaler_reset_o || (sfio_wr && wr_shrst));
    endproperty
    a_release: assert property (p_release) else $error("reset bits survived hold release");

    property p_self_clear;
        @(posedge clk_i) disable iff (rst_i)
        sfio_wr && wr_shrst && !wr_hold |-> shared_prescaler_reset_o ##1 !sfio_r.shared_rst;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("unheld prescaler reset not one cycle");

endmodule : stpcs_top
